// file: pesl_event_status.sv
// Event status and enable register with clear-on-read pending flags
// Notes on behaviour
// RULE1 - A pending flag sets when its event occurred since the last status read.
// RULE2 - An event with its enable set raises the interrupt.
// RULE3 - Interrupts also need the global interrupt controls to permit them.
// RULE4 - Pending flags latch whether or not any enable is set.
// RULE5 - Bit 15 is link quality pending, resets to 0, clears on read.
// RULE6 - Bit 14 is energy detect pending, resets to 0, clears on read.
// RULE7 - Bit 13 is link status change pending, resets to 0, clears on read.
// RULE8 - Bit 12 flags speed change, or speed/duplex change when mapping select is 1.
// RULE9 - Bit 11 flags duplex change, or time-sync event when mapping select is 1.
// RULE10 - Time-sync interrupt re-arms only after time-sync status reports empty.
// RULE11 - Bit 10 is auto-negotiation complete pending, resets to 0, clears on read.
// RULE12 - Bit 9 flags false-carrier half-full, or any counter when select bits set.
// RULE13 - Lower byte holds read-write per-event enables, reset to 0.
// RULE14 - Global enable gates interrupts; output enable turns shared pin into interrupt.
// RULE15 - Read clears only returned flags; events during the read stay pending.
`timescale 1ns/1ps
module pesl_event_status (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [4:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  input wire logic i_evt_link_quality,
  input wire logic i_evt_energy_detect,
  input wire logic i_evt_link_change,
  input wire logic i_evt_speed_change,
  input wire logic i_evt_duplex_change,
  input wire logic i_evt_time_sync,
  input wire logic i_time_sync_status_empty,
  input wire logic i_evt_autoneg_done,
  input wire logic i_evt_false_carrier_half,
  input wire logic i_evt_rx_error_half,
  input wire logic [1:0] i_counter_select,
  output logic [15:0] o_rdata,
  output logic o_int_n,
  output logic o_int_pin_oe
);
  // Position of each source inside the seven-bit pending vector
  localparam int LQ_IDX = pesl_pkg::BIT_LQ - pesl_pkg::EVT_LSB;
  localparam int ED_IDX = pesl_pkg::BIT_ED - pesl_pkg::EVT_LSB;
  localparam int LINK_IDX = pesl_pkg::BIT_LINK - pesl_pkg::EVT_LSB;
  localparam int SPD_IDX = pesl_pkg::BIT_SPD - pesl_pkg::EVT_LSB;
  localparam int DUP_IDX = pesl_pkg::BIT_DUP - pesl_pkg::EVT_LSB;
  localparam int ANC_IDX = pesl_pkg::BIT_ANC - pesl_pkg::EVT_LSB;
  localparam int CTR_IDX = pesl_pkg::BIT_CTR - pesl_pkg::EVT_LSB;
  // Enable byte bounds and the top of the pending field
  localparam int EN_MSB = pesl_pkg::EN_SHIFT - 1;
  localparam int EN_OFS = pesl_pkg::EVT_LSB - pesl_pkg::EN_SHIFT;
  localparam int TOP = pesl_pkg::DATA_W - 1;

  // Registered state, each with its next value
  logic [pesl_pkg::NUM_EVT-1:0] pend_reg;
  logic [pesl_pkg::NUM_EVT-1:0] pend_next;
  logic [EN_MSB:0] en_reg;
  logic [EN_MSB:0] en_next;
  logic [TOP:0] ctrl_reg;
  logic [TOP:0] ctrl_next;
  logic [TOP:0] rdata_reg;
  logic [TOP:0] rdata_next;
  logic int_n_reg;
  logic int_n_next;
  logic oe_reg;
  logic oe_next;
  logic ts_armed_reg;
  logic ts_armed_next;

  // Decoded strobes, control fields and mapped event sources
  logic rd_status;
  logic rd_ctrl;
  logic wr_status;
  logic wr_ctrl;
  logic map_sel;
  logic global_en;
  logic test_force;
  logic pin_is_int;
  logic ctr_wide;
  logic ts_fire;
  logic ts_rearm;
  logic spd_src;
  logic dup_src;
  logic ctr_src;
  logic any_fire;
  logic [pesl_pkg::NUM_EVT-1:0] evt_vec;
  logic [pesl_pkg::NUM_EVT-1:0] en_vec;
  logic [pesl_pkg::NUM_EVT-1:0] fire_vec;
  logic [TOP:0] status_word;
  logic [TOP:0] ctrl_word;

  // Address compare shared by every read and write decode
  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    hit = (a == target);
  endfunction

  // Takes the alternate source when its select is set
  function automatic logic pick_source(input logic alt_sel, input logic normal, input logic alt);
    if (alt_sel) begin
      pick_source = alt;
    end else begin
      pick_source = normal;
    end
  endfunction

  // One flag: a read clears it, but an event in that same cycle sets it again
  function automatic logic flag_next(input logic cur, input logic clr, input logic set);
    flag_next = cur;
    if (clr) begin
      flag_next = 1'b0;
    end
    if (set) begin
      flag_next = 1'b1;
    end
  endfunction

  // Register selects
  always_comb begin
    rd_status = i_rd && hit(i_addr, pesl_pkg::EVT_STATUS_ADDR);
    rd_ctrl = i_rd && hit(i_addr, pesl_pkg::INT_CTRL_ADDR);
    wr_status = i_wr && hit(i_addr, pesl_pkg::EVT_STATUS_ADDR);
    wr_ctrl = i_wr && hit(i_addr, pesl_pkg::INT_CTRL_ADDR);
  end

  always_comb begin
    map_sel = ctrl_reg[pesl_pkg::CTL_MAP_SEL];
    global_en = ctrl_reg[pesl_pkg::CTL_GLOBAL_EN];
    test_force = ctrl_reg[pesl_pkg::CTL_TEST];
    pin_is_int = ctrl_reg[pesl_pkg::CTL_OUT_EN];
    ctr_wide = |i_counter_select;
  end

  // One flag per drain of the time-sync status, so a burst of stamps raises one interrupt
  always_comb begin
    ts_fire = i_evt_time_sync && ts_armed_reg; // RULE10
    ts_rearm = i_time_sync_status_empty && !i_evt_time_sync;
    ts_armed_next = ts_armed_reg;
    if (ts_fire) begin
      ts_armed_next = 1'b0;
    end else if (ts_rearm) begin
      ts_armed_next = 1'b1; // RULE10
    end
  end

  // Reset leaves the time-sync path armed so its first event is seen
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ts_armed_reg <= 1'b1;
    end else begin
      ts_armed_reg <= ts_armed_next;
    end
  end

  // Route each source to its flag position
  // Counter select of zero keeps only the false-carrier source
  always_comb begin
    spd_src = pick_source(map_sel, i_evt_speed_change, i_evt_speed_change | i_evt_duplex_change);
    dup_src = pick_source(map_sel, i_evt_duplex_change, ts_fire);
    ctr_src = pick_source(ctr_wide, i_evt_false_carrier_half, i_evt_false_carrier_half | i_evt_rx_error_half);
    evt_vec = '0;
    evt_vec[LQ_IDX] = i_evt_link_quality; // RULE5
    evt_vec[ED_IDX] = i_evt_energy_detect; // RULE6
    evt_vec[LINK_IDX] = i_evt_link_change; // RULE7
    evt_vec[SPD_IDX] = spd_src; // RULE8
    evt_vec[DUP_IDX] = dup_src; // RULE9
    evt_vec[ANC_IDX] = i_evt_autoneg_done; // RULE11
    evt_vec[CTR_IDX] = ctr_src; // RULE12
  end

  // Enables sit a fixed distance below their pending flags
  genvar g;
  generate
    for (g = 0; g < pesl_pkg::NUM_EVT; g = g + 1) begin : g_evt
      // An event fires only while its own enable is set
      assign en_vec[g] = en_reg[g + EN_OFS]; // RULE13
      assign fire_vec[g] = evt_vec[g] && en_vec[g]; // RULE2
    end
  endgenerate

  // Latch regardless of any enable; the read returns all flags, so all may clear
  always_comb begin
    pend_next = pend_reg;
    for (int i = 0; i < pesl_pkg::NUM_EVT; i++) begin
      pend_next[i] = flag_next(pend_reg[i], rd_status, evt_vec[i]); // RULE1 RULE4 RULE15
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Enable bit zero stays read-as-zero through the write mask
  always_comb begin
    en_next = en_reg;
    if (wr_status) begin
      en_next = i_wdata[EN_MSB:0] & pesl_pkg::EN_MASK[EN_MSB:0]; // RULE13
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_reg <= pesl_pkg::RESET_VAL[EN_MSB:0];
    end else begin
      en_reg <= en_next;
    end
  end

  // Reserved control bits are never stored
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = i_wdata & pesl_pkg::CTL_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= pesl_pkg::RESET_VAL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Read words: reserved bits always read zero
  always_comb begin
    status_word = pesl_pkg::RESET_VAL;
    status_word[TOP:pesl_pkg::EVT_LSB] = pend_reg; // RULE5 RULE6 RULE7 RULE11
    status_word[EN_MSB:0] = en_reg; // RULE13
  end

  always_comb begin
    ctrl_word = pesl_pkg::RESET_VAL;
    ctrl_word[pesl_pkg::CTL_MAP_SEL] = map_sel;
    ctrl_word[pesl_pkg::CTL_TEST] = test_force;
    ctrl_word[pesl_pkg::CTL_GLOBAL_EN] = global_en;
    ctrl_word[pesl_pkg::CTL_OUT_EN] = pin_is_int;
  end

  // Read data holds until the next read, so a slow poller may sample it late
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_status) begin
      rdata_next = status_word;
    end else if (rd_ctrl) begin
      rdata_next = ctrl_word;
    end else if (i_rd) begin
      rdata_next = pesl_pkg::RESET_VAL;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= pesl_pkg::RESET_VAL;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Low for each cycle an enabled event fires while global enable is set; the test bit holds the line low
  always_comb begin
    any_fire = |fire_vec;
    int_n_next = 1'b1;
    if (global_en && any_fire) begin
      int_n_next = 1'b0; // RULE2 RULE3 RULE14
    end
    if (test_force) begin
      int_n_next = 1'b0; // RULE3
    end
  end

  // Line idles high while nothing is signalled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      int_n_reg <= 1'b1;
    end else begin
      int_n_reg <= int_n_next;
    end
  end

  // Pin direction follows the control word as it is written, with no extra lag
  // Shared pin stays an input until the output enable is written
  always_comb begin
    oe_next = ctrl_next[pesl_pkg::CTL_OUT_EN]; // RULE14
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_int_n = int_n_reg;
  assign o_int_pin_oe = oe_reg;
endmodule

// file: pesl_event_status_asserts.sv
// Checker for the event status latch ports
`timescale 1ns/1ps
module pesl_event_status_asserts (
  input wire logic i_clk, i_rst, i_rd, i_wr, i_evt_link_quality, i_evt_energy_detect,
  input wire logic i_evt_link_change, i_evt_autoneg_done, o_int_n, o_int_pin_oe,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata, o_rdata
);
  wire rs = i_rd && i_addr == 5'h12;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_RST: assert property ($past(i_rst) |-> !o_rdata && o_int_n && !o_int_pin_oe) else $error("rst");
  AST_OE: assert property (i_wr && i_addr == 5'h11 |=> o_int_pin_oe == $past(i_wdata[0])) else $error("oe");
  AST_LQ: assert property (i_evt_link_quality ##1 rs |=> o_rdata[15]) else $error("lq");
  AST_ED: assert property (i_evt_energy_detect ##1 rs |=> o_rdata[14]) else $error("ed");
  AST_LINK: assert property (i_evt_link_change ##1 rs |=> o_rdata[13]) else $error("link");
  AST_ANC: assert property (i_evt_autoneg_done ##1 rs |=> o_rdata[10]) else $error("anc");
  AST_COR: assert property (rs && !i_evt_link_change ##1 rs |=> !o_rdata[13]) else $error("cor");
  AST_HOLD: assert property (!i_rd |=> $stable(o_rdata)) else $error("hold");
  cover property (rs ##1 o_rdata[13]);
  cover property (!o_int_n);
  cover property (i_wr && i_addr == 5'h11);
endmodule
bind pesl_event_status pesl_event_status_asserts u_chk (.*);

// file: pesl_mgmt_model.sv
// Management controller model making one-strobe register accesses
`timescale 1ns/1ps
module pesl_mgmt_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [4:0] o_addr = 5'h0,
  output logic o_rd = 1'b0,
  output logic o_wr = 1'b0,
  output logic [15:0] o_wdata = 16'h0
);
  // Write data flips once taken so a stale word never looks valid
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge i_clk);
    {o_addr, o_rd, o_wr, o_wdata} <= {a, !w, w, wd};
    @(posedge i_clk);
    {o_rd, o_wr, o_wdata} <= {2'b0, ~wd};
    @(posedge i_clk);
    rd = i_rdata;
  endtask
endmodule

// file: pesl_pkg.sv
// Package with register layout and field positions of the event status latch
package pesl_pkg;
  localparam logic [4:0] EVT_STATUS_ADDR = 5'h12;
  localparam logic [4:0] INT_CTRL_ADDR = 5'h11;
  localparam int DATA_W = 16;
  // Pending flag bit positions in the upper byte
  localparam int BIT_LQ = 15;
  localparam int BIT_ED = 14;
  localparam int BIT_LINK = 13;
  localparam int BIT_SPD = 12;
  localparam int BIT_DUP = 11;
  localparam int BIT_ANC = 10;
  localparam int BIT_CTR = 9;
  // Enable bits sit eight below their pending flag
  localparam int EN_SHIFT = 8;
  localparam int NUM_EVT = 7;
  localparam int EVT_LSB = 9;
  // Interrupt control fields
  localparam int CTL_MAP_SEL = 3;
  localparam int CTL_TEST = 2;
  localparam int CTL_GLOBAL_EN = 1;
  localparam int CTL_OUT_EN = 0;
  localparam logic [15:0] CTL_MASK = 16'h000f;
  localparam logic [15:0] EN_MASK = 16'h00fe;
  localparam logic [15:0] RESET_VAL = 16'h0000;
endpackage

// file: phy_event_status_latch_tb.sv
// Self-checking bench for the event status latch
`timescale 1ns/1ps
module phy_event_status_latch_tb;
  logic i_clk = 0, i_rst = 1, emp = 1, rd, wr, int_n, oe, seen;
  logic [1:0] sel = 0;
  logic [8:0] ev = 0;
  logic [4:0] addr;
  logic [15:0] wd, rdata, r;
  logic [31:0] seed = 32'h5e73;
  int fail_count = 0, check_count = 0;
  always #10 i_clk = ~i_clk;
  pesl_mgmt_model mm (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wd));
  pesl_event_status dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wd),
    .i_evt_link_quality(ev[6]), .i_evt_energy_detect(ev[5]), .i_evt_link_change(ev[4]),
    .i_evt_speed_change(ev[3]), .i_evt_duplex_change(ev[2]), .i_evt_time_sync(ev[7]),
    .i_time_sync_status_empty(emp), .i_evt_autoneg_done(ev[1]), .i_evt_false_carrier_half(ev[0]),
    .i_evt_rx_error_half(ev[8]), .i_counter_select(sel), .o_rdata(rdata), .o_int_n(int_n), .o_int_pin_oe(oe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] exp_flags(input logic [8:0] m, input logic [1:0] cs);
    return {m[6:1], m[0] | (m[8] & (cs != 2'h0)), 9'h020};
  endfunction
  task automatic chk(input string n, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge i_clk) ev <= m;
    @(posedge i_clk) ev <= 9'h0;
    #1 seen = int_n;
  endtask
  task automatic rs(input string n, input logic [15:0] e);
    mm.acc(0, 5'h12, 16'h0, r);
    chk(n, r, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000 fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 0;
    rs("reset", 16'h0);
    for (int i = 0; i < 7; i++) begin
      pulse(9'h1 << i);
      rs("flag", 16'h200 << i);
      rs("cleared", 16'h0);
    end
    seed = xs(seed);
    mm.acc(1, 5'h12, seed[15:0], r);
    rs("enables", seed[15:0] & 16'h00fe);
    $display("test events done");
    mm.acc(1, 5'h12, 16'h0020, r);
    mm.acc(1, 5'h11, 16'h0003, r);
    pulse(9'h10);
    chk("int", 16'(seen), 16'h0);
    mm.acc(1, 5'h11, 16'h0001, r);
    pulse(9'h10);
    chk("masked", 16'(seen), 16'h1);
    chk("oe", 16'(oe), 16'h1);
    rs("latched", 16'h2020);
    mm.acc(1, 5'h11, 16'h0008, r);
    @(posedge i_clk) emp <= 0;
    pulse(9'h084);
    rs("map", 16'h1820);
    pulse(9'h080);
    rs("unarmed", 16'h0020);
    @(posedge i_clk) emp <= 1;
    pulse(9'h080);
    rs("rearmed", 16'h0820);
    @(posedge i_clk) sel <= 2'h1;
    pulse(9'h100);
    rs("counter", 16'h0220);
    fork
      rs("race", 16'h0020);
      pulse(9'h040);
    join
    rs("kept", 16'h8020);
    mm.acc(1, 5'h11, 16'h0004, r);
    @(posedge i_clk) #1 chk("test", 16'(int_n), 16'h0);
    mm.acc(0, 5'h11, 16'h0, r);
    chk("ctrl", r, 16'h0004);
    mm.acc(1, 5'h11, 16'h0000, r);
    chk("oe off", 16'(oe), 16'h0);
    $display("test control done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      @(posedge i_clk) sel <= seed[10:9];
      pulse(seed[8:0] & 9'h17f);
      rs("random", exp_flags(seed[8:0] & 9'h17f, seed[10:9]));
    end
    $display("test random done");
    tally_and_finish;
  end
endmodule
